// File: rtl/alert_minmax_defs.svh
// Function
// - hysteresis register 05h, reset 0, field 11:2
// - alert self clears only beyond hysteresis margin
// - alert hold set: no self clearing
// - reserved bits 15:12, 1:0 read zero
// - lowest register 06h, reset 0fffh, field 11:2
// - auto mode: keep lower result as minimum
// - writing 0fffh restarts minimum tracking
// - min/max update only in automatic mode
// - highest register 07h, reset 0, field 11:2
// - auto mode: keep higher result as maximum
// - writing 0000h restarts maximum tracking
// - same behaviour at every bus rate
// - lines only pulled low, never driven high
// - ack own address, release otherwise
// - ack every received write byte
// - repeated start restarts address, new r/w bit sets mode
// - stop is sda rise with scl high
// - held alert cleared by writing one
// - limits compared after every conversion
// - nonzero cycle time means automatic mode
`ifndef ALERT_MINMAX_DEFS_SVH
`define ALERT_MINMAX_DEFS_SVH
`define REG_HYST_PTR 8'h05
`define REG_LOWEST_PTR 8'h06
`define REG_HIGHEST_PTR 8'h07
`define HYST_RESET 16'h0000
`define LOWEST_RESET 16'h0fff
`define HIGHEST_RESET 16'h0000
`define FIELD_MSB 11
`define FIELD_LSB 2
`define SLAVE_ADDR_DEFAULT 7'h54
`endif

// File: rtl/alert_minmax_pkg.sv
package alert_minmax_pkg;
  typedef logic [9:0] sample_t;
  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_ADDR  = 7'h02,
    ST_PTR   = 7'h04,
    ST_WDATA = 7'h08,
    ST_ACK   = 7'h10,
    ST_TX    = 7'h20,
    ST_RACK  = 7'h40
  } i2c_state_t;
endpackage

// File: rtl/result_handshake_cdc.sv
`timescale 1ns/1ps
`default_nettype none
module result_handshake_cdc (
  input wire logic i_conv_clk, // converter clock
  input wire logic i_conv_rst_n, // converter reset, sync
  input wire logic i_conv_valid, // result offered
  input wire alert_minmax_pkg::sample_t i_conv_data, // result value
  output logic o_conv_ready, // result taken this edge
  input wire logic i_clk, // device clock
  input wire logic i_rst_n, // device reset, sync
  output logic o_valid, // one-cycle result pulse
  output alert_minmax_pkg::sample_t o_data // result, registered
);
  import alert_minmax_pkg::*;

  // ----------------------------------------
  // converter side
  // ----------------------------------------
  logic req_q;
  logic seen_q;
  logic ack_s1_q;
  logic ack_s2_q;
  sample_t data_q;
  wire busy = req_q ^ ack_s2_q;
  assign o_conv_ready = ~busy;

  always_ff @(posedge i_conv_clk) begin
    if (!i_conv_rst_n) begin
      req_q <= 1'b0;
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
      data_q <= '0;
    end else begin
      ack_s1_q <= seen_q;
      ack_s2_q <= ack_s1_q;
      if (i_conv_valid && !busy) begin
        data_q <= i_conv_data;
        req_q <= ~req_q;
      end
    end
  end

  // ----------------------------------------
  // device side
  // ----------------------------------------
  logic req_s1_q;
  logic req_s2_q;
  wire take = req_s2_q ^ seen_q;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      seen_q <= 1'b0;
      o_valid <= 1'b0;
      o_data <= '0;
    end else begin
      req_s1_q <= req_q;
      req_s2_q <= req_s1_q;
      seen_q <= req_s2_q;
      o_valid <= take;
      if (take) begin
        o_data <= data_q;
      end
    end
  end
endmodule
`default_nettype wire

// File: rtl/alert_minmax_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "alert_minmax_defs.svh"
module alert_minmax_regs #(
  parameter logic [6:0] SLAVE_ADDR = `SLAVE_ADDR_DEFAULT,
  parameter int RES_BITS = 10
) (
  input wire logic i_clk, // device clock, 125 MHz
  input wire logic i_rst_n, // sync reset, active low
  input wire logic i_conv_clk, // converter clock
  input wire logic i_conv_rst_n, // converter reset, sync
  input wire logic i_conv_valid, // conversion complete
  input wire alert_minmax_pkg::sample_t i_conv_data, // conversion result
  output logic o_conv_ready, // result accepted
  input wire logic i_scl, // bus clock pin
  input wire logic i_sda_i, // bus data pin level
  output logic o_sda_o, // bus data drive value
  output logic o_sda_oe, // bus data pulled low
  input wire logic [2:0] i_cycle_time, // automatic cycle time
  input wire logic i_alert_hold, // alerts sticky
  input wire alert_minmax_pkg::sample_t i_upper_limit, // over-range limit
  input wire alert_minmax_pkg::sample_t i_lower_limit, // under-range limit
  input wire logic i_clr_over, // write-one clear, over
  input wire logic i_clr_under, // write-one clear, under
  output logic o_over_alert, // over-range flag
  output logic o_under_alert, // under-range flag
  output alert_minmax_pkg::sample_t o_last_result // latest result
);
  import alert_minmax_pkg::*;

  if (RES_BITS != `FIELD_MSB - `FIELD_LSB + 1) begin : g_bad_width
    $error("result width must match register field");
  end
  if (SLAVE_ADDR[6:3] == 4'h0) begin : g_bad_addr
    $error("slave address lies in reserved range");
  end

  localparam logic [7:0] PTR_HYST = `REG_HYST_PTR;
  localparam logic [7:0] PTR_LOWEST = `REG_LOWEST_PTR;
  localparam logic [7:0] PTR_HIGHEST = `REG_HIGHEST_PTR;
  localparam logic [15:0] HYST_RST_W = `HYST_RESET;
  localparam logic [15:0] LOWEST_RST_W = `LOWEST_RESET;
  localparam logic [15:0] HIGHEST_RST_W = `HIGHEST_RESET;
  localparam sample_t HYST_RST = HYST_RST_W[`FIELD_MSB:`FIELD_LSB];
  localparam sample_t LOWEST_RST = LOWEST_RST_W[`FIELD_MSB:`FIELD_LSB];
  localparam sample_t HIGHEST_RST = HIGHEST_RST_W[`FIELD_MSB:`FIELD_LSB];

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic sample_t sat_sub(input sample_t a, input sample_t b);
    sat_sub = (a > b) ? sample_t'(a - b) : '0;
  endfunction
  function automatic sample_t sat_add(input sample_t a, input sample_t b);
    logic [10:0] s;
    s = {1'b0, a} + {1'b0, b};
    sat_add = s[10] ? '1 : s[9:0];
  endfunction
  function automatic logic [15:0] place(input sample_t f);
    place = {4'h0, f, 2'b00};
  endfunction

  // ----------------------------------------
  // conversion results
  // ----------------------------------------
  logic res_vld;
  sample_t res;

  result_handshake_cdc u_cdc (
    .i_conv_clk(i_conv_clk),
    .i_conv_rst_n(i_conv_rst_n),
    .i_conv_valid(i_conv_valid),
    .i_conv_data(i_conv_data),
    .o_conv_ready(o_conv_ready),
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .o_valid(res_vld),
    .o_data(res)
  );
  assign o_last_result = res;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [2:0] scl_sync_q;
  logic [2:0] sda_sync_q;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      scl_sync_q <= 3'h7;
      sda_sync_q <= 3'h7;
    end else begin
      scl_sync_q <= {scl_sync_q[1:0], i_scl};
      sda_sync_q <= {sda_sync_q[1:0], i_sda_i};
    end
  end

  // oversampled edges, independent of bus rate
  wire scl_rise = scl_sync_q[1] & ~scl_sync_q[2];
  wire scl_fall = ~scl_sync_q[1] & scl_sync_q[2];
  wire scl_high = scl_sync_q[1] & scl_sync_q[2];
  wire bus_start = scl_high & sda_sync_q[2] & ~sda_sync_q[1];
  wire bus_stop = scl_high & ~sda_sync_q[2] & sda_sync_q[1];

  // ----------------------------------------
  // serial slave
  // ----------------------------------------
  i2c_state_t state_q;
  i2c_state_t state_d;
  i2c_state_t nxt_q;
  i2c_state_t nxt_d;
  logic [3:0] bit_cnt_q;
  logic [7:0] rx_q;
  logic [7:0] tx_q;
  logic [7:0] ptr_q;
  logic [7:0] hold_q;
  logic lo_q;
  logic mack_q;
  logic sda_oe_q;

  wire rx_state = (state_q == ST_ADDR) | (state_q == ST_PTR) | (state_q == ST_WDATA);
  wire byte_done = rx_state & (bit_cnt_q == 4'h8) & scl_fall;
  wire addr_match = (rx_q[7:1] == SLAVE_ADDR);
  wire wr_strobe = (state_q == ST_WDATA) & byte_done & lo_q;
  wire [15:0] wr_word = {hold_q, rx_q};
  wire wr_hyst = wr_strobe & (ptr_q == PTR_HYST);
  wire wr_lowest = wr_strobe & (ptr_q == PTR_LOWEST);
  wire wr_highest = wr_strobe & (ptr_q == PTR_HIGHEST);
  wire sample_t wr_field = wr_word[`FIELD_MSB:`FIELD_LSB];
  sample_t hyst_q;
  sample_t min_q;
  sample_t max_q;
  wire [15:0] rd_word = (ptr_q == PTR_HYST) ? place(hyst_q) :
                        (ptr_q == PTR_LOWEST) ? place(min_q) :
                        (ptr_q == PTR_HIGHEST) ? place(max_q) : 16'h0000;
  wire [7:0] tx_byte = lo_q ? rd_word[7:0] : rd_word[15:8];
  wire load_tx = ((state_q == ST_ACK) & (nxt_q == ST_TX) & scl_fall) |
                 ((state_q == ST_RACK) & ~mack_q & scl_fall);

  always_comb begin
    state_d = state_q;
    nxt_d = nxt_q;
    if (bus_stop) begin
      state_d = ST_IDLE;
    end else if (bus_start) begin
      state_d = ST_ADDR;
    end else begin
      case (state_q)
        ST_ADDR: begin
          if (byte_done && addr_match) begin
            state_d = ST_ACK;
            nxt_d = rx_q[0] ? ST_TX : ST_PTR;
          end else if (byte_done) begin
            state_d = ST_IDLE;
          end
        end
        ST_PTR: begin
          if (byte_done) begin
            state_d = ST_ACK;
            nxt_d = ST_WDATA;
          end
        end
        ST_WDATA: begin
          if (byte_done) begin
            state_d = ST_ACK;
            nxt_d = ST_WDATA;
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            state_d = nxt_q;
          end
        end
        ST_TX: begin
          if (scl_fall && bit_cnt_q == 4'h7) begin
            state_d = ST_RACK;
          end
        end
        ST_RACK: begin
          if (scl_fall) begin
            state_d = mack_q ? ST_IDLE : ST_TX;
          end
        end
        default: begin
          state_d = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_q <= ST_IDLE;
      nxt_q <= ST_IDLE;
      sda_oe_q <= 1'b0;
    end else begin
      state_q <= state_d;
      nxt_q <= nxt_d;
      sda_oe_q <= (state_q == ST_ACK) | ((state_q == ST_TX) & ~tx_q[7]);
    end
  end

  // only ever pull the line low
  assign o_sda_o = 1'b0;
  assign o_sda_oe = sda_oe_q;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n || bus_start || bus_stop || state_q == ST_IDLE) begin
      bit_cnt_q <= 4'h0;
    end else if (rx_state && scl_rise) begin
      bit_cnt_q <= bit_cnt_q + 4'h1;
    end else if (load_tx || (state_q == ST_ACK && scl_fall)) begin
      bit_cnt_q <= 4'h0;
    end else if (state_q == ST_TX && scl_fall) begin
      bit_cnt_q <= bit_cnt_q + 4'h1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rx_q <= 8'h00;
      tx_q <= 8'hff;
      mack_q <= 1'b1;
    end else begin
      if (rx_state && scl_rise) begin
        rx_q <= {rx_q[6:0], sda_sync_q[1]};
      end
      if (load_tx) begin
        tx_q <= tx_byte;
      end else if (state_q == ST_TX && scl_fall) begin
        tx_q <= {tx_q[6:0], 1'b1};
      end
      if (state_q == ST_RACK && scl_rise) begin
        mack_q <= sda_sync_q[1];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ptr_q <= 8'h00;
      hold_q <= 8'h00;
      lo_q <= 1'b0;
    end else begin
      if (bus_start || (state_q == ST_ADDR && byte_done)) begin
        lo_q <= 1'b0;
      end else if (load_tx || (state_q == ST_WDATA && byte_done)) begin
        lo_q <= ~lo_q;
      end
      if (state_q == ST_PTR && byte_done) begin
        ptr_q <= rx_q;
      end
      if (state_q == ST_WDATA && byte_done && !lo_q) begin
        hold_q <= rx_q;
      end
    end
  end

  // ----------------------------------------
  // hysteresis, lowest and highest registers
  // ----------------------------------------
  wire auto_mode = (i_cycle_time != 3'h0);
  wire track = res_vld & auto_mode;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      hyst_q <= HYST_RST;
      min_q <= LOWEST_RST;
      max_q <= HIGHEST_RST;
    end else begin
      if (wr_hyst) begin
        hyst_q <= wr_field;
      end
      if (wr_lowest) begin
        min_q <= wr_field;
      end else if (track && res < min_q) begin
        min_q <= res;
      end
      if (wr_highest) begin
        max_q <= wr_field;
      end else if (track && res > max_q) begin
        max_q <= res;
      end
    end
  end

  // ----------------------------------------
  // alert flags
  // ----------------------------------------
  wire sample_t over_thr = sat_sub(i_upper_limit, hyst_q);
  wire sample_t under_thr = sat_add(i_lower_limit, hyst_q);
  wire over_set = res_vld & (res > i_upper_limit);
  wire under_set = res_vld & (res < i_lower_limit);
  wire over_self = res_vld & ~i_alert_hold & (res < over_thr);
  wire under_self = res_vld & ~i_alert_hold & (res > under_thr);

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_over_alert <= 1'b0;
      o_under_alert <= 1'b0;
    end else begin
      o_over_alert <= over_set | (o_over_alert & ~i_clr_over & ~over_self);
      o_under_alert <= under_set | (o_under_alert & ~i_clr_under & ~under_self);
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  reset_vals_a: assert property ($rose(i_rst_n) |-> hyst_q == HYST_RST &&
    min_q == LOWEST_RST && max_q == HIGHEST_RST) else $error("register reset values wrong");
  rsvd_zero_a: assert property (rd_word[15:12] == 4'h0 && rd_word[1:0] == 2'b00)
    else $error("reserved bits not zero");
  min_track_a: assert property (track && !wr_lowest && res < min_q |=> min_q == $past(res))
    else $error("minimum not updated");
  max_track_a: assert property (track && !wr_highest && res > max_q |=> max_q == $past(res))
    else $error("maximum not updated");
  normal_keep_a: assert property (!auto_mode && !wr_lowest && !wr_highest |=>
    $stable(min_q) && $stable(max_q)) else $error("min or max moved in normal mode");
  min_restart_a: assert property (wr_lowest && wr_word == LOWEST_RST_W |=>
    min_q == LOWEST_RST) else $error("minimum not restarted");
  sticky_hold_a: assert property (i_alert_hold && o_over_alert && !i_clr_over |=>
    o_over_alert) else $error("held alert cleared by itself");
  margin_hold_a: assert property (o_under_alert && !i_clr_under &&
    !(res_vld && res > under_thr) |=> o_under_alert) else $error("alert cleared inside margin");
  alert_set_a: assert property (res_vld && res > i_upper_limit |=> o_over_alert)
    else $error("over alert not raised");
  addr_nack_a: assert property (state_q == ST_ADDR && byte_done && !addr_match &&
    !bus_start && !bus_stop |=> state_q == ST_IDLE ##1 !o_sda_oe)
    else $error("foreign address acknowledged");
  wdata_ack_a: assert property (state_q == ST_WDATA && byte_done && !bus_start && !bus_stop
    |=> ##1 o_sda_oe) else $error("write byte not acknowledged");

  read_cv: cover property (state_q == ST_RACK && scl_fall && !mack_q);
  write_cv: cover property (wr_hyst || wr_lowest || wr_highest);
  clear_cv: cover property (o_over_alert && over_self && !i_alert_hold);
endmodule
`default_nettype wire

// File: bench/i2c_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model #(
  parameter int QTR = 8
) (
  input wire logic i_clk, // pacing clock
  input wire logic i_sda, // resolved data line
  output logic o_scl, // clock line, 1 = released
  output logic o_sda // data line, 1 = released
);
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end

  task automatic hold_q();
    repeat (QTR) @(negedge i_clk);
  endtask

  // start, or repeated start from mid-transfer
  task automatic start_cond();
    o_sda = 1'b1;
    hold_q();
    o_scl = 1'b1;
    hold_q();
    o_sda = 1'b0;
    hold_q();
    o_scl = 1'b0;
    hold_q();
  endtask

  task automatic stop_cond();
    o_sda = 1'b0;
    hold_q();
    o_scl = 1'b1;
    hold_q();
    o_sda = 1'b1;
    hold_q();
  endtask

  task automatic put_bit(input logic b, output logic seen);
    o_sda = b;
    hold_q();
    o_scl = 1'b1;
    hold_q();
    seen = i_sda;
    hold_q();
    o_scl = 1'b0;
    hold_q();
  endtask

  task automatic wbyte(input logic [7:0] d, output logic ack_n);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i], s);
    end
    put_bit(1'b1, ack_n);
  endtask

  task automatic rbyte(input logic ack_n, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, d[i]);
    end
    put_bit(ack_n, s);
  endtask
endmodule
`default_nettype wire

// File: bench/alert_minmax_regs_i2c_slave_bench.sv
`timescale 1ns/1ps
`default_nettype none
module alert_minmax_regs_i2c_slave_bench;
  import alert_minmax_pkg::*;
  localparam logic [6:0] SLV = 7'h54;
  logic i_clk, i_rst_n, conv_clk, conv_rst_n, conv_valid, conv_ready;
  logic scl, m_sda, sda, sda_o, sda_oe, hold, clr_over, clr_under, over, under;
  logic [2:0] cycle_time;
  sample_t conv_data, upper, lower, last_result;
  int errors, n_compared, cycles;
  logic [12:0] tab [9];

  assign sda = sda_oe ? 1'b0 : m_sda;

  i2c_master_model #(.QTR(8)) mst (.i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda(m_sda));

  alert_minmax_regs #(.SLAVE_ADDR(SLV), .RES_BITS(10)) uut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_conv_clk(conv_clk), .i_conv_rst_n(conv_rst_n),
    .i_conv_valid(conv_valid), .i_conv_data(conv_data), .o_conv_ready(conv_ready),
    .i_scl(scl), .i_sda_i(sda), .o_sda_o(sda_o), .o_sda_oe(sda_oe),
    .i_cycle_time(cycle_time), .i_alert_hold(hold), .i_upper_limit(upper),
    .i_lower_limit(lower), .i_clr_over(clr_over), .i_clr_under(clr_under),
    .o_over_alert(over), .o_under_alert(under), .o_last_result(last_result));

  always #4 i_clk = ~i_clk;
  initial begin
    conv_clk = 1'b0;
    #3;
    forever #24 conv_clk = ~conv_clk;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic close_out();
    $display("compared=%0d errors=%0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic send(input logic [7:0] d);
    logic a;
    mst.wbyte(d, a);
    check({15'h0, a}, 16'h0000);
  endtask

  task automatic reg_write(input logic [7:0] ptr, input logic [15:0] d);
    mst.start_cond();
    send({SLV, 1'b0});
    send(ptr);
    send(d[15:8]);
    send(d[7:0]);
    mst.stop_cond();
  endtask

  task automatic reg_read(input logic [7:0] ptr, input logic [15:0] exp);
    logic [7:0] hi, lo;
    mst.start_cond();
    send({SLV, 1'b0});
    send(ptr);
    mst.start_cond();
    send({SLV, 1'b1});
    mst.rbyte(1'b0, hi);
    mst.rbyte(1'b1, lo);
    mst.stop_cond();
    check({hi, lo}, exp);
  endtask

  task automatic convert(input sample_t v);
    int k;
    @(negedge conv_clk);
    conv_valid = 1'b1;
    conv_data = v;
    k = 0;
    while (conv_ready !== 1'b1 && k < 50) begin
      @(negedge conv_clk);
      k++;
    end
    if (k >= 50) begin
      errors++;
    end
    @(posedge conv_clk);
    @(negedge conv_clk);
    conv_valid = 1'b0;
    repeat (20) @(negedge i_clk);
  endtask

  task automatic pulse(input logic which);
    @(negedge i_clk);
    if (which) clr_over = 1'b1;
    else clr_under = 1'b1;
    @(negedge i_clk);
    clr_over = 1'b0;
    clr_under = 1'b0;
    repeat (4) @(negedge i_clk);
  endtask

  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      errors++;
      close_out();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic a;
    i_clk = 1'b0;
    i_rst_n = 1'b0;
    conv_rst_n = 1'b0;
    conv_valid = 1'b0;
    conv_data = '0;
    upper = 10'h300;
    lower = 10'h100;
    cycle_time = 3'h0;
    hold = 1'b0;
    clr_over = 1'b0;
    clr_under = 1'b0;
    errors = 0;
    n_compared = 0;
    cycles = 0;
    tab = '{{1'b0, 10'h301, 2'b10}, {1'b0, 10'h2f0, 2'b10}, {1'b0, 10'h2ef, 2'b00},
            {1'b0, 10'h0ff, 2'b01}, {1'b0, 10'h110, 2'b01}, {1'b0, 10'h111, 2'b00},
            {1'b1, 10'h301, 2'b10}, {1'b1, 10'h000, 2'b11}, {1'b1, 10'h200, 2'b11}};
    repeat (10) @(negedge i_clk);
    i_rst_n = 1'b1;
    repeat (4) @(negedge conv_clk);
    conv_rst_n = 1'b1;
    repeat (10) @(negedge i_clk);

    reg_read(8'h05, 16'h0000);
    reg_read(8'h06, 16'h0ffc);
    reg_read(8'h07, 16'h0000);
    mst.start_cond();
    mst.wbyte(8'h08, a);
    check({15'h0, a}, 16'h0001);
    mst.start_cond();
    mst.wbyte({7'h55, 1'b0}, a);
    check({15'h0, a}, 16'h0001);
    mst.stop_cond();
    $display("test reset_and_address done");

    reg_write(8'h05, 16'h0124);
    reg_read(8'h05, 16'h0124);
    reg_write(8'h06, 16'h03a8);
    reg_read(8'h06, 16'h03a8);
    reg_write(8'h07, 16'h0ffc);
    reg_read(8'h07, 16'h0ffc);
    reg_write(8'h08, 16'h0ffc);
    reg_read(8'h08, 16'h0000);
    $display("test reserved_bits done");

    reg_write(8'h06, 16'h0fff);
    reg_write(8'h07, 16'h0000);
    convert(10'h100);
    check({6'h0, last_result}, 16'h0100);
    reg_read(8'h06, 16'h0ffc);
    reg_read(8'h07, 16'h0000);
    foreach (tab[i]) begin
      if (i < 4) begin
        cycle_time = 3'(i + 1);
        convert(i == 0 ? 10'h100 : i == 1 ? 10'h080 : i == 2 ? 10'h200 : 10'h150);
      end
    end
    reg_read(8'h06, 16'h0200);
    reg_read(8'h07, 16'h0800);
    $display("test tracking done");

    reg_write(8'h06, 16'h0fff);
    reg_write(8'h07, 16'h0000);
    cycle_time = 3'h7;
    convert(10'h150);
    reg_read(8'h06, 16'h0540);
    reg_read(8'h07, 16'h0540);
    $display("test restart done");

    reg_write(8'h05, 16'h0040);
    foreach (tab[i]) begin
      hold = tab[i][12];
      convert(tab[i][11:2]);
      check({14'h0, over, under}, {14'h0, tab[i][1:0]});
    end
    pulse(1'b1);
    check({14'h0, over, under}, 16'h0001);
    pulse(1'b0);
    check({14'h0, over, under}, 16'h0000);
    check({15'h0, sda_o}, 16'h0000);
    $display("test alerts done");
    close_out();
  end
endmodule
`default_nettype wire
